// [inc/synth_pkg.sv]
// Shared constants and types for both ends of the synthesizer serial bus.
package synth_pkg;
  localparam int WORD_BITS = 24;
  localparam int PREP_CLKS = 4;
  localparam int READ_BITS = 9;
  localparam int REF_EDGES = 4;
  localparam int SEL_POS = 22;
  localparam int TEST_SUB_POS = 21;
  localparam logic [1:0] SEL_FRAC = 2'h0;
  localparam logic [1:0] SEL_DIV = 2'h1;
  localparam logic [1:0] SEL_CFG = 2'h2;
  localparam logic [1:0] SEL_TEST = 2'h3;
  localparam int N_POS = 0;
  localparam int PD_RF_POS = 9;
  localparam int PD_IF_POS = 10;
  localparam int PDREF_POS = 11;
  localparam int R_POS = 12;
  localparam int READ_REQ_POS = 11;
  localparam int FORCE_SPU_POS = 15;
  localparam int DIS_SPU_POS = 16;
  localparam int PUMP_SEL_POS = 5;
  localparam logic [21:0] FRAC_RST = 22'h035BA7;
  localparam logic [21:0] DIV_RST = 22'h05166C;
  localparam logic [21:0] CFG_RST = 22'h000000;
  localparam logic [20:0] TEST_RST = 21'h000000;
  localparam int T_CY_NS = 100;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CY_MIN_CYC = (T_CY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] OFS_WORD = 8'h00;
  localparam logic [7:0] OFS_HOLD = 8'h04;
  localparam logic [7:0] OFS_PON = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  localparam logic [15:0] HOLD_RST = 16'h0010;
  typedef enum logic [2:0] {H_IDLE, H_SHIFT, H_HIGH, H_READ, H_LOW} host_state_t;
endpackage

// [inc/serial3_if.sv]
// Three-wire programming bus with its shared data line and power pin.
`timescale 1ns/1ps
`default_nettype none
interface serial3_if;
  logic sclk;
  logic strobe;
  logic host_do;
  logic host_oe_n;
  logic dev_do;
  logic dev_oe_n;
  logic hw_power_pin;
  wire data_line;
  // Undriven line is pulled high.
  assign data_line = !dev_oe_n ? dev_do : (!host_oe_n ? host_do : 1'b1);
  modport ctl (output sclk, output strobe, output host_do, output host_oe_n, output hw_power_pin, input data_line);
  modport dev (input sclk, input strobe, input data_line, input hw_power_pin, output dev_do, output dev_oe_n);
endinterface
`default_nettype wire

// [rtl/synth_serial_device.sv]
// Device end: serial word capture, speed-up, lock, power and read-back.
//
// Overview of operation
// - strobe rise after fraction word starts speed-up
// - strobe fall ends speed-up; IF never
// - upper pump gain bit disables integral pump
// - host limits strobe width to charge time
// - force bit holds speed-up on
// - disable bit suppresses speed-up entirely
// - lock needs both loops; one powered-down loop counts, both down gives no lock
// - power state is pin XOR software bits
// - serial bus works during power-down
// - powered down, ratio applied at strobe fall
// - power changes never reset the modulator
// - host resends divider word for pre-load
// - host toggles power pin after strobe fall
// - reactivation syncs IF and reference dividers
// - RF detector enabled after four reference edges
// - power-on reset loads all default words
// - shift while strobe low, latch while high
// - host sends configuration, divider, fraction words
// - new integer ratio waits for fraction word
// - fraction load does not reset modulator
// - read request, four prep, nine data clocks
// - strobe fall releases data line at once
// - words are 24 bits, LSB first
// - top bits select the target word
`timescale 1ns/1ps
`default_nettype none
module synth_serial_device
(
  input wire logic ref_clk,
  input wire logic rst_n,
  serial3_if.dev bus,
  input wire logic rf_lock_det,
  input wire logic if_lock_det,
  input wire logic ref_div_out,
  input wire logic [8:0] momentary_ratio,
  output logic [22:0] fraction_value,
  output logic [8:0] rf_int_ratio,
  output logic [9:0] ref_ratio,
  output logic ref_div_reset,
  output logic [21:0] cfg_word,
  output logic [20:0] test_word,
  output logic rf_powered,
  output logic if_powered,
  output logic rf_main_pump_fast_current,
  output logic rf_integral_pump_fast,
  output logic rf_integral_pump_en,
  output logic lock,
  output logic if_ref_sync,
  output logic rf_pd_enable,
  output logic mod_clear
);
  localparam logic [3:0] PREP_LAST = 4'(synth_pkg::PREP_CLKS - 1);
  localparam logic [3:0] READ_END = 4'(synth_pkg::PREP_CLKS + synth_pkg::READ_BITS);
  localparam logic [2:0] REF_LAST = 3'(synth_pkg::REF_EDGES - 1);

  logic [3:0] pin_in;
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] s3_r;
  logic sclk_rise;
  logic stb;
  logic stb_rise;
  logic stb_fall;
  logic din;
  logic hw_power_pin;
  logic [23:0] shift_r;
  logic [1:0] wsel;
  logic is_a;
  logic is_b;
  logic is_c;
  logic is_d;
  logic [21:0] frac_r;
  logic [21:0] div_r;
  logic [8:0] n_apply_r;
  logic n_pend_r;
  logic [21:0] cfg_r;
  logic [20:0] test_r;
  logic rf_up;
  logic if_up;
  logic spu_r;
  logic fast_nxt;
  logic rf_up_r;
  logic if_up_r;
  logic sync_r;
  logic lock_r;
  logic fast_r;
  logic int_fast_r;
  logic int_en_r;
  logic ref_prev_r;
  logic [2:0] ref_cnt_r;
  logic pd_en_r;
  logic rd_mode_r;
  logic [3:0] rcnt_r;
  logic [8:0] out_sh_r;
  logic oe_n_r;
  logic clr_r;

  // Every bus pin comes from the far side, so each crosses two flops first.
  assign pin_in = {bus.hw_power_pin, bus.data_line, bus.strobe, bus.sclk};

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
      s3_r <= 4'h0;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign sclk_rise = s2_r[0] && !s3_r[0];
  assign stb = s2_r[1];
  assign stb_rise = s2_r[1] && !s3_r[1];
  assign stb_fall = !s2_r[1] && s3_r[1];
  assign din = s2_r[2];
  assign hw_power_pin = s2_r[3];

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      shift_r <= 24'h000000;
    else if (!stb && sclk_rise)
      shift_r <= {din, shift_r[23:1]};
  end

  assign wsel = shift_r[synth_pkg::SEL_POS +: 2];
  assign is_a = stb_rise && (wsel == synth_pkg::SEL_FRAC);
  assign is_b = stb_rise && (wsel == synth_pkg::SEL_DIV);
  assign is_c = stb_rise && (wsel == synth_pkg::SEL_CFG);
  assign is_d = stb_rise && (wsel == synth_pkg::SEL_TEST) && !shift_r[synth_pkg::TEST_SUB_POS];

  assign rf_up = hw_power_pin ^ div_r[synth_pkg::PD_RF_POS];
  assign if_up = hw_power_pin ^ div_r[synth_pkg::PD_IF_POS];

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frac_r <= synth_pkg::FRAC_RST;
      div_r <= synth_pkg::DIV_RST;
      cfg_r <= synth_pkg::CFG_RST;
      test_r <= synth_pkg::TEST_RST;
    end
    else
    begin
      if (is_a)
        frac_r <= shift_r[21:0];
      if (is_b)
        div_r <= shift_r[21:0];
      if (is_c)
        cfg_r <= shift_r[21:0];
      if (is_d)
        test_r <= shift_r[20:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      n_apply_r <= synth_pkg::DIV_RST[8:0];
      n_pend_r <= 1'b0;
    end
    else if (is_a && rf_up)
      n_apply_r <= div_r[synth_pkg::N_POS +: 9];
    else if (is_a)
      n_pend_r <= 1'b1;
    else if (stb_fall && n_pend_r)
    begin
      n_apply_r <= div_r[synth_pkg::N_POS +: 9];
      n_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      spu_r <= 1'b0;
    else if (stb_fall)
      spu_r <= 1'b0;
    else if (is_a)
      spu_r <= 1'b1;
  end

  assign fast_nxt = !test_r[synth_pkg::DIS_SPU_POS] && (spu_r || test_r[synth_pkg::FORCE_SPU_POS]);

  // The IF pump has no fast path at all, so no output exists for it.
  // gain bit kills integral
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fast_r <= 1'b0;
      int_fast_r <= 1'b0;
      int_en_r <= 1'b0;
    end
    else
    begin
      fast_r <= fast_nxt;
      int_fast_r <= fast_nxt && !cfg_r[synth_pkg::PUMP_SEL_POS];
      int_en_r <= !cfg_r[synth_pkg::PUMP_SEL_POS];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rf_up_r <= 1'b0;
      if_up_r <= 1'b0;
      sync_r <= 1'b0;
      lock_r <= 1'b0;
    end
    else
    begin
      rf_up_r <= rf_up;
      if_up_r <= if_up;
      sync_r <= if_up && !if_up_r;
      lock_r <= (rf_up || if_up) && (!rf_up || (rf_lock_det && pd_en_r)) && (!if_up || if_lock_det);
    end
  end

  // The RF divider gets no power-up alignment; its phase starts free.
  // four reference edges
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_prev_r <= 1'b0;
      ref_cnt_r <= 3'h0;
      pd_en_r <= 1'b0;
    end
    else
    begin
      ref_prev_r <= ref_div_out;
      if (!rf_up || div_r[synth_pkg::PDREF_POS])
      begin
        ref_cnt_r <= 3'h0;
        pd_en_r <= 1'b0;
      end
      else if (!pd_en_r && (ref_div_out != ref_prev_r))
      begin
        ref_cnt_r <= ref_cnt_r + 3'h1;
        pd_en_r <= (ref_cnt_r == REF_LAST);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_mode_r <= 1'b0;
      rcnt_r <= 4'h0;
      out_sh_r <= 9'h000;
      oe_n_r <= 1'b1;
    end
    else if (stb_fall)
    begin
      rd_mode_r <= 1'b0;
      oe_n_r <= 1'b1;
    end
    else if (stb_rise)
    begin
      rd_mode_r <= is_d && shift_r[synth_pkg::READ_REQ_POS];
      rcnt_r <= 4'h0;
    end
    else if (rd_mode_r && stb && sclk_rise && (rcnt_r < READ_END))
    begin
      rcnt_r <= rcnt_r + 4'h1;
      if (rcnt_r == PREP_LAST)
      begin
        out_sh_r <= momentary_ratio;
        oe_n_r <= 1'b0;
      end
      else if (rcnt_r > PREP_LAST)
        out_sh_r <= {1'b0, out_sh_r[8:1]};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      clr_r <= 1'b1;
    else
      clr_r <= 1'b0;
  end

  assign bus.dev_do = out_sh_r[0];
  assign bus.dev_oe_n = oe_n_r;
  assign fraction_value = {frac_r, 1'b1};
  assign rf_int_ratio = n_apply_r;
  assign ref_ratio = div_r[synth_pkg::R_POS +: 10];
  assign ref_div_reset = div_r[synth_pkg::PDREF_POS];
  assign cfg_word = cfg_r;
  assign test_word = test_r;
  assign rf_powered = rf_up_r;
  assign if_powered = if_up_r;
  assign rf_main_pump_fast_current = fast_r;
  assign rf_integral_pump_fast = int_fast_r;
  assign rf_integral_pump_en = int_en_r;
  assign lock = lock_r;
  assign if_ref_sync = sync_r;
  assign rf_pd_enable = pd_en_r;
  assign mod_clear = clr_r;
endmodule // synth_serial_device
`default_nettype wire

// [rtl/synth_serial_host.sv]
// Host end: AHB-Lite registers driving word writes and read-back.
`timescale 1ns/1ps
`default_nettype none
module synth_serial_host
#(
  parameter int HALF = 4
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  serial3_if.ctl bus
);
  // Read-back data must cross both synchronisers within one serial period.
  if (HALF < 4 || 2 * HALF < synth_pkg::CY_MIN_CYC)
    $error("HALF too small for the read-back round trip");

  localparam logic [7:0] HALF_LAST = 8'(HALF - 1);
  localparam logic [4:0] LAST_BIT = 5'(synth_pkg::WORD_BITS - 1);
  localparam logic [4:0] PREP = 5'(synth_pkg::PREP_CLKS);
  localparam logic [4:0] RD_LAST = 5'(synth_pkg::PREP_CLKS + synth_pkg::READ_BITS - 1);

  synth_pkg::host_state_t state_r;
  logic [7:0] div_r;
  logic tick;
  logic ph_we_r;
  logic [7:0] ph_addr_r;
  logic take;
  logic start;
  logic [31:0] rd_mux;
  logic [31:0] hrdata_r;
  logic [15:0] hold_r;
  logic pon_req_r;
  logic pon_r;
  logic [23:0] sh_r;
  logic [4:0] bit_r;
  logic [15:0] hcnt_r;
  logic sclk_r;
  logic stb_r;
  logic oe_n_r;
  logic rd_word_r;
  logic [8:0] rd_r;
  logic [8:0] rdata_r;
  logic d1_r;
  logic d2_r;

  assign take = hsel && hready && htrans[1];
  assign start = ph_we_r && (ph_addr_r == synth_pkg::OFS_WORD) && (state_r == synth_pkg::H_IDLE);
  assign tick = (div_r == HALF_LAST);

  always_comb
  begin
    rd_mux = 32'h00000000;
    case (haddr[7:0])
      synth_pkg::OFS_HOLD: rd_mux = {16'h0000, hold_r};
      synth_pkg::OFS_PON: rd_mux = {31'h00000000, pon_req_r};
      synth_pkg::OFS_STAT: rd_mux = {31'h00000000, state_r != synth_pkg::H_IDLE};
      synth_pkg::OFS_RDATA: rd_mux = {23'h000000, rdata_r};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_we_r <= 1'b0;
      ph_addr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
      hold_r <= synth_pkg::HOLD_RST;
      pon_req_r <= 1'b0;
    end
    else
    begin
      ph_we_r <= take && hwrite;
      if (take)
        ph_addr_r <= haddr[7:0];
      if (take && !hwrite)
        hrdata_r <= rd_mux;
      if (ph_we_r && ph_addr_r == synth_pkg::OFS_HOLD)
        hold_r <= hwdata[15:0];
      if (ph_we_r && ph_addr_r == synth_pkg::OFS_PON)
        pon_req_r <= hwdata[0];
    end
  end

  // The data line comes back from the device, so it is synchronised.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      d1_r <= 1'b1;
      d2_r <= 1'b1;
    end
    else
    begin
      d1_r <= bus.data_line;
      d2_r <= d1_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_r <= 8'h00;
    else if (state_r == synth_pkg::H_IDLE || tick)
      div_r <= 8'h00;
    else
      div_r <= div_r + 8'h01;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= synth_pkg::H_IDLE;
      sh_r <= 24'h000000;
      bit_r <= 5'h00;
      hcnt_r <= 16'h0000;
      sclk_r <= 1'b0;
      stb_r <= 1'b0;
      oe_n_r <= 1'b1;
      rd_word_r <= 1'b0;
      rd_r <= 9'h000;
      rdata_r <= 9'h000;
      pon_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        synth_pkg::H_IDLE:
        begin
          pon_r <= pon_req_r;
          if (start)
          begin
            sh_r <= hwdata[23:0];
            bit_r <= 5'h00;
            oe_n_r <= 1'b0;
            rd_word_r <= (hwdata[23:21] == {synth_pkg::SEL_TEST, 1'b0}) && hwdata[synth_pkg::READ_REQ_POS];
            state_r <= synth_pkg::H_SHIFT;
          end
        end
        synth_pkg::H_SHIFT:
          if (tick && !sclk_r)
            sclk_r <= 1'b1;
          else if (tick)
          begin
            sclk_r <= 1'b0;
            sh_r <= {1'b0, sh_r[23:1]};
            bit_r <= bit_r + 5'h01;
            if (bit_r == LAST_BIT)
            begin
              oe_n_r <= 1'b1;
              stb_r <= 1'b1;
              bit_r <= 5'h00;
              hcnt_r <= 16'h0000;
              state_r <= rd_word_r ? synth_pkg::H_READ : synth_pkg::H_HIGH;
            end
          end
        synth_pkg::H_HIGH:
        begin
          hcnt_r <= hcnt_r + 16'h0001;
          if (hcnt_r >= hold_r)
          begin
            stb_r <= 1'b0;
            state_r <= synth_pkg::H_LOW;
          end
        end
        synth_pkg::H_READ:
          if (tick && !sclk_r)
          begin
            sclk_r <= 1'b1;
            if (bit_r >= PREP)
              rd_r <= {d2_r, rd_r[8:1]};
          end
          else if (tick)
          begin
            sclk_r <= 1'b0;
            bit_r <= bit_r + 5'h01;
            if (bit_r == RD_LAST)
            begin
              stb_r <= 1'b0;
              rdata_r <= rd_r;
              state_r <= synth_pkg::H_LOW;
            end
          end
        synth_pkg::H_LOW:
          if (tick)
            state_r <= synth_pkg::H_IDLE;
        default:
          state_r <= synth_pkg::H_IDLE;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign bus.sclk = sclk_r;
  assign bus.strobe = stb_r;
  assign bus.host_do = sh_r[0];
  assign bus.host_oe_n = oe_n_r;
  assign bus.hw_power_pin = pon_r;
endmodule // synth_serial_host
`default_nettype wire

// [tb/synth_serial_properties.sv]
// Checker for the three-wire bus between the host and device ends.
`timescale 1ns/1ps
`default_nettype none
module synth_serial_properties
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic strobe,
  input wire logic host_do,
  input wire logic host_oe_n,
  input wire logic dev_oe_n,
  input wire logic hw_power_pin
);
  logic sclk_q_r;
  logic [5:0] lo_cnt_r;
  logic [5:0] hi_cnt_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Rising serial clocks are counted apart for the shift phase and the latch phase.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_q_r <= 1'b0;
      lo_cnt_r <= 6'h00;
      hi_cnt_r <= 6'h00;
    end
    else
    begin
      sclk_q_r <= sclk;
      lo_cnt_r <= strobe ? 6'h00 : lo_cnt_r + 6'(sclk && !sclk_q_r);
      hi_cnt_r <= !strobe ? 6'h00 : hi_cnt_r + 6'(sclk && !sclk_q_r);
    end
  end
  no_clash_a:
    assert property (!(!host_oe_n && !dev_oe_n)) else $error("host and device drive data together");
  release_fast_a:
    assert property ($fell(strobe) |-> ##[0:4] dev_oe_n) else $error("data line not released after strobe fall");
  latch_quiet_a:
    assert property ($rose(strobe) |-> !sclk && host_oe_n) else $error("strobe rose with clock or data active");
  word_length_a:
    assert property ($rose(strobe) |-> lo_cnt_r == 6'h18) else $error("word length is not 24 clocks");
  read_clocks_a:
    assert property ($fell(strobe) |-> hi_cnt_r == 6'h00 || hi_cnt_r == 6'h0D) else $error("read clock count wrong");
  read_prep_a:
    assert property ((!dev_oe_n && strobe) |-> hi_cnt_r >= 6'h04) else $error("device drove before four clocks");
  pin_quiet_a:
    assert property ($changed(hw_power_pin) |-> !$past(strobe) && $past(host_oe_n)) else $error("power pin moved mid word");
  data_hold_a:
    assert property ((sclk && !host_oe_n) |-> $stable(host_do)) else $error("host data moved while clock high");
endmodule // synth_serial_properties
`default_nettype wire

// [tb/synth_serial_control_test.sv]
// Bench joining host and device ends over the three-wire bus.
`timescale 1ns/1ps
`default_nettype none
module synth_serial_control_test;
  logic ref_clk, rst_n, hsel, hwrite, hreadyout, hresp, rf_lock_det, if_lock_det, ref_div_out, seen;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [8:0] momentary_ratio, rf_int_ratio, n_val, m_val;
  logic [22:0] fraction_value;
  logic [9:0] ref_ratio;
  logic [21:0] cfg_word, w;
  logic [20:0] test_word;
  logic ref_div_reset, rf_powered, if_powered, rf_main_pump_fast_current, rf_integral_pump_fast;
  logic rf_integral_pump_en, lock, if_ref_sync, rf_pd_enable, mod_clear;
  int error_cnt, checked, cycles;
  serial3_if u_serial3_if();
  synth_serial_host #(.HALF(4)) u_synth_serial_host (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .bus(u_serial3_if.ctl));
  synth_serial_device u_synth_serial_device (.ref_clk, .rst_n, .bus(u_serial3_if.dev), .rf_lock_det, .if_lock_det,
    .ref_div_out, .momentary_ratio, .fraction_value, .rf_int_ratio, .ref_ratio, .ref_div_reset, .cfg_word, .test_word,
    .rf_powered, .if_powered, .rf_main_pump_fast_current, .rf_integral_pump_fast, .rf_integral_pump_en, .lock,
    .if_ref_sync, .rf_pd_enable, .mod_clear);
  synth_serial_properties u_synth_serial_properties (.ref_clk, .rst_n, .sclk(u_serial3_if.sclk),
    .strobe(u_serial3_if.strobe), .host_do(u_serial3_if.host_do), .host_oe_n(u_serial3_if.host_oe_n),
    .dev_oe_n(u_serial3_if.dev_oe_n), .hw_power_pin(u_serial3_if.hw_power_pin));
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask
  task automatic cmp_flag(input string s, input logic e, input logic g);
    cmp(s, 32'(e), 32'(g));
  endtask
  function automatic logic exp_lock(input logic rfu, input logic ifu, input logic rfl, input logic ifl);
    return (rfu || ifu) && (!rfu || rfl) && (!ifu || ifl);
  endfunction
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    @(posedge ref_clk);
    while (hreadyout !== 1'b1)
      @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1)
      @(posedge ref_clk);
    rd = hrdata;
  endtask
  // Busy is polled over the bus; the bench timeout bounds a hang.
  task automatic wait_idle();
    rd = 32'h00000001;
    while (rd[0] !== 1'b0)
      ahb(1'b0, synth_pkg::OFS_STAT, 32'h00000000);
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic send(input logic [23:0] x);
    ahb(1'b1, synth_pkg::OFS_WORD, {8'h00, x});
    wait_idle();
  endtask
  task automatic send_watch(input logic [23:0] x, input logic fast, input logic [8:0] n_hi);
    int hi;
    ahb(1'b1, synth_pkg::OFS_WORD, {8'h00, x});
    while (u_serial3_if.strobe !== 1'b1)
      @(posedge ref_clk);
    repeat (8) @(posedge ref_clk);
    cmp_flag("speedup_high", fast, rf_main_pump_fast_current);
    cmp_flag("integral_fast", 1'b0, rf_integral_pump_fast);
    cmp("ratio_high", 32'(n_hi), 32'(rf_int_ratio));
    hi = 8;
    while (u_serial3_if.strobe !== 1'b0)
    begin
      @(posedge ref_clk);
      hi++;
    end
    // The bench programs a hold of 0x28, so the strobe stands 0x29 cycles.
    cmp("strobe_width", 32'h00000029, 32'(hi));
    repeat (8) @(posedge ref_clk);
    cmp_flag("speedup_low", 1'b0, rf_main_pump_fast_current);
    wait_idle();
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    ref_div_out <= ~ref_div_out;
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    rf_lock_det = 1'b0;
    if_lock_det = 1'b0;
    ref_div_out = 1'b0;
    momentary_ratio = 9'h000;
    error_cnt = 0;
    checked = 0;
    cycles = 0;
    void'($urandom(32'h49FE7255));
    repeat (3) @(posedge ref_clk);
    cmp_flag("mod_clear_rst", 1'b1, mod_clear);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    cmp("fraction", 32'({synth_pkg::FRAC_RST, 1'b1}), 32'(fraction_value));
    cmp("int_ratio", 32'(synth_pkg::DIV_RST[8:0]), 32'(rf_int_ratio));
    cmp("ref_ratio", 32'(synth_pkg::DIV_RST[21:12]), 32'(ref_ratio));
    cmp("cfg", 32'(synth_pkg::CFG_RST), 32'(cfg_word));
    cmp("test", 32'(synth_pkg::TEST_RST), 32'(test_word));
    cmp_flag("rf_up", synth_pkg::DIV_RST[9], rf_powered);
    cmp_flag("ref_reset_rst", synth_pkg::DIV_RST[11], ref_div_reset);
    cmp_flag("hresp", 1'b0, hresp);
    ahb(1'b0, synth_pkg::OFS_HOLD, 32'h00000000);
    cmp("hold_rst", 32'(synth_pkg::HOLD_RST), rd);
    ahb(1'b1, 8'h14, 32'hFFFFFFFF);
    ahb(1'b0, 8'h14, 32'h00000000);
    cmp("unmapped", 32'h00000000, rd);
    ahb(1'b1, synth_pkg::OFS_HOLD, 32'hFFFFFFFF);
    ahb(1'b0, synth_pkg::OFS_HOLD, 32'h00000000);
    cmp("hold_rw", 32'h0000FFFF, rd);
    ahb(1'b1, synth_pkg::OFS_HOLD, 32'h00000028);
    done("reset");
    for (int i = 0; i < 2; i++)
    begin
      w = 22'($urandom);
      w[5] = i[0];
      send({2'b10, w});
      cmp("cfg", 32'(w), 32'(cfg_word));
      cmp_flag("integral_en", !w[5], rf_integral_pump_en);
    end
    w = 22'($urandom) & 22'h1E77FF;
    send({3'b110, w[20:0]});
    cmp("test", 32'(w[20:0]), 32'(test_word));
    send({3'b111, ~w[20:0]});
    cmp("test_kept", 32'(w[20:0]), 32'(test_word));
    send(24'hC00000);
    done("decode");
    n_val = 9'(33 + $urandom % 477);
    m_val = 9'(33 + $urandom % 477);
    w = 22'($urandom);
    send({2'b01, w[21:12], 3'b011, n_val});
    cmp("int_kept", 32'(synth_pkg::DIV_RST[8:0]), 32'(rf_int_ratio));
    cmp("ref_ratio", 32'(w[21:12]), 32'(ref_ratio));
    send_watch({2'b00, w}, 1'b1, n_val);
    cmp("fraction", 32'({w, 1'b1}), 32'(fraction_value));
    cmp("int_new", 32'(n_val), 32'(rf_int_ratio));
    ahb(1'b1, synth_pkg::OFS_WORD, 32'h00800123);
    ahb(1'b1, synth_pkg::OFS_WORD, 32'h00800456);
    wait_idle();
    cmp("cfg_busy", 32'h00000123, 32'(cfg_word));
    done("order");
    send({2'b01, 10'h010, 3'b000, m_val});
    cmp_flag("rf_down", 1'b0, rf_powered);
    cmp_flag("lock_down", 1'b0, lock);
    send_watch({2'b00, w}, 1'b1, n_val);
    cmp("int_late", 32'(m_val), 32'(rf_int_ratio));
    send_watch({2'b01, 10'h010, 3'b011, m_val}, 1'b0, m_val);
    cmp_flag("rf_back", 1'b1, rf_powered);
    send(24'hC10000);
    send_watch({2'b00, w}, 1'b0, m_val);
    send(24'hC08000);
    cmp_flag("spu_forced", 1'b1, rf_main_pump_fast_current);
    send(24'hC00000);
    cmp_flag("spu_off", 1'b0, rf_main_pump_fast_current);
    done("speedup");
    send({2'b01, 10'h010, 3'b111, m_val});
    cmp_flag("ref_reset", 1'b1, ref_div_reset);
    cmp_flag("pd_ref_off", 1'b0, rf_pd_enable);
    for (int i = 0; i < 8; i++)
    begin
      send({2'b01, 10'h010, 1'b0, i[1:0], m_val});
      ahb(1'b1, synth_pkg::OFS_PON, 32'(i[2]));
      rf_lock_det <= 1'($urandom);
      if_lock_det <= 1'($urandom);
      repeat (12) @(posedge ref_clk);
      cmp_flag("rf_pow", i[2] ^ i[0], rf_powered);
      cmp_flag("if_pow", i[2] ^ i[1], if_powered);
      cmp_flag("lock", exp_lock(i[2] ^ i[0], i[2] ^ i[1], rf_lock_det, if_lock_det), lock);
    end
    ahb(1'b1, synth_pkg::OFS_PON, 32'h00000000);
    seen = 1'b0;
    while (rf_powered !== 1'b1)
    begin
      @(posedge ref_clk);
      seen = seen | if_ref_sync;
    end
    cmp_flag("pd_wait", 1'b0, rf_pd_enable);
    repeat (12)
    begin
      @(posedge ref_clk);
      seen = seen | if_ref_sync;
    end
    cmp_flag("pd_on", 1'b1, rf_pd_enable);
    cmp_flag("if_sync", 1'b1, seen);
    done("power");
    momentary_ratio <= 9'($urandom);
    send(24'hC00800);
    ahb(1'b0, synth_pkg::OFS_RDATA, 32'h00000000);
    cmp("readback", 32'(momentary_ratio), rd);
    send(24'hC00000);
    cmp_flag("mod_kept", 1'b0, mod_clear);
    done("readback");
    finish_test();
  end
endmodule // synth_serial_control_test
`default_nettype wire
